// ===== tfscr_regs.sv
// Front end and synthesizer calibration register bank with level ramping.
//
// Functional notes
// (R1) Three-bit index picks steady table entry.
// (R2) ASK one uses index, zero uses entry 0.
// (R3) Ramp entries zero to index at edges.
// (R4) Bits 5:4 set buffer drive, reset one.
// (R5) Pump enable zero skips pump stage; reset 2.
// (R6) Low nibble holds pump current, reset nine.
// (R7) Host writes calibration config before calibrating.
// (R8) Host-written calibration values used without recalibrating.
// (R9) Bit five selects high oscillator core.
// (R10) Low six bits hold oscillator current, reset ten.
// (R11) Unused bits read zero, ignore writes.
`timescale 1ns/10ps
module tfscr_regs
   import tfscr_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       reset_n,
   input  wire logic [5:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_rd,
   output logic [7:0]      reg_rdata,
   input  wire logic       cal_update,
   input  wire logic [3:0] cal_pump_result,
   input  wire logic [5:0] cal_osc_result,
   input  wire logic       tx_active,
   input  wire logic       ask_mode,
   input  wire logic       tx_symbol,
   output logic [2:0]      power_level_index,
   output logic [1:0]      lo_buffer_drive_setting,
   output logic [1:0]      pump_cal_config,
   output logic [1:0]      pump_cal_stage_enable,
   output logic            pump_cal_skip,
   output logic [3:0]      pump_current,
   output logic            oscillator_core_high_select,
   output logic [5:0]      oscillator_current,
   output logic [2:0]      table_index,
   output logic            ramp_busy
);
   // ****************************************************************
   // Register state.
   // ****************************************************************
   logic [2:0] pli_r;
   logic [2:0] pli_nxt;
   logic [1:0] lob_r;
   logic [1:0] lob_nxt;
   logic [1:0] pcfg_r;
   logic [1:0] pcfg_nxt;
   logic [1:0] pen_r;
   logic [1:0] pen_nxt;
   logic [3:0] pcur_r;
   logic [3:0] pcur_nxt;
   logic [5:0] ocur_r;
   logic [5:0] ocur_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic       wr_fe;
   logic       wr_pump;
   logic       wr_osc;
   logic       step;

   assign wr_fe   = reg_wr && (reg_addr == TFSCR_OFS_FRONT_END);
   assign wr_pump = reg_wr && (reg_addr == TFSCR_OFS_CAL_PUMP);
   assign wr_osc  = reg_wr && (reg_addr == TFSCR_OFS_CAL_OSC);

   // ****************************************************************
   // Next register values.
   // ****************************************************************
   // A host write in the same cycle as a calibration result wins only for the
   // register it writes; the result still replaces the other calibration value.
   always_comb begin
      pli_nxt  = pli_r;
      lob_nxt  = lob_r;
      pcfg_nxt = pcfg_r;
      pen_nxt  = pen_r;
      pcur_nxt = pcur_r;
      ocur_nxt = ocur_r;
      if (wr_fe) begin
         pli_nxt = reg_wdata[TFSCR_PLI_LSB +: TFSCR_PLI_W];   // R1
         lob_nxt = reg_wdata[TFSCR_LOB_LSB +: TFSCR_LOB_W];   // R4
      end
      if (cal_update) begin
         pcur_nxt = cal_pump_result;   // R6
         ocur_nxt = cal_osc_result;    // R10
      end
      if (wr_pump) begin
         pcfg_nxt = reg_wdata[TFSCR_PCFG_LSB +: TFSCR_PCFG_W];   // R7
         pen_nxt  = reg_wdata[TFSCR_PEN_LSB +: TFSCR_PEN_W];     // R5
         pcur_nxt = reg_wdata[TFSCR_PCUR_LSB +: TFSCR_PCUR_W];   // R6 R8
      end
      if (wr_osc) begin
         ocur_nxt = reg_wdata[TFSCR_OCUR_LSB +: TFSCR_OCUR_W];   // R8 R10
      end
   end

   // ****************************************************************
   // Read data.
   // ****************************************************************
   always_comb begin
      rdata_nxt = rdata_r;
      if (reg_rd) begin
         case (reg_addr)
            TFSCR_OFS_FRONT_END: begin
               rdata_nxt = {2'h0, lob_r, 1'b0, pli_r};   // R11
            end
            TFSCR_OFS_CAL_PUMP: begin
               rdata_nxt = {pcfg_r, pen_r, pcur_r};
            end
            TFSCR_OFS_CAL_OSC: begin
               rdata_nxt = {2'h0, ocur_r};   // R11
            end
            default: begin
               rdata_nxt = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         pli_r   <= TFSCR_RST_PLI;    // R1
         lob_r   <= TFSCR_RST_LOB;    // R4
         pcfg_r  <= TFSCR_RST_PCFG;   // R7
         pen_r   <= TFSCR_RST_PEN;    // R5
         pcur_r  <= TFSCR_RST_PCUR;   // R6
         ocur_r  <= TFSCR_RST_OCUR;   // R9 R10
         rdata_r <= 8'h00;
      end else begin
         pli_r   <= pli_nxt;
         lob_r   <= lob_nxt;
         pcfg_r  <= pcfg_nxt;
         pen_r   <= pen_nxt;
         pcur_r  <= pcur_nxt;
         ocur_r  <= ocur_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // ****************************************************************
   // Outputs toward the analog front end and calibration engine.
   // ****************************************************************
   assign reg_rdata                   = rdata_r;
   assign power_level_index           = pli_r;
   assign lo_buffer_drive_setting     = lob_r;
   assign pump_cal_config             = pcfg_r;
   assign pump_cal_stage_enable       = pen_r;
   assign pump_cal_skip               = (pen_r == 2'h0);   // R5
   assign pump_current                = pcur_r;
   // The core select shares bit five with the current result.
   assign oscillator_core_high_select = ocur_r[TFSCR_CORE_BIT];   // R9
   assign oscillator_current          = ocur_r;

   // ****************************************************************
   // Output level ramp.
   // ****************************************************************
   // The pacer only runs while there is somewhere to go or a frame.
   tfscr_step_div u_step_div (
      .clock   (clock),
      .reset_n (reset_n),
      .run     (tx_active || (table_index != 3'h0)),
      .step    (step)
   );

   tfscr_level_seq u_level_seq (
      .clock             (clock),
      .reset_n           (reset_n),
      .step              (step),
      .tx_active         (tx_active),
      .ask_mode          (ask_mode),
      .tx_symbol         (tx_symbol),
      .power_level_index (pli_r),
      .table_index       (table_index),
      .ramp_busy         (ramp_busy)
   );

   // ****************************************************************
   // Checks.
   // ****************************************************************
   chk_index_write: assert property ( // R1
      @(posedge clock) disable iff (!reset_n)
      wr_fe |=> power_level_index == $past(reg_wdata[2:0]))
      else $error("power level index not taken from write");

   chk_index_hold: assert property ( // R1
      @(posedge clock) disable iff (!reset_n)
      !wr_fe |=> $stable(power_level_index))
      else $error("power level index changed without a write");

   chk_drive_write: assert property ( // R4
      @(posedge clock) disable iff (!reset_n)
      wr_fe |=> lo_buffer_drive_setting == $past(reg_wdata[5:4]))
      else $error("buffer drive not taken from write");

   chk_drive_hold: assert property ( // R4
      @(posedge clock) disable iff (!reset_n)
      !wr_fe |=> $stable(lo_buffer_drive_setting))
      else $error("buffer drive changed without a write");

   chk_pump_skip: assert property ( // R5
      @(posedge clock) disable iff (!reset_n)
      (wr_pump && reg_wdata[5:4] == 2'h0) |=> pump_cal_skip)
      else $error("pump stage not skipped after zero enable");

   chk_enable_write: assert property ( // R5
      @(posedge clock) disable iff (!reset_n)
      wr_pump |=> pump_cal_stage_enable == $past(reg_wdata[5:4]))
      else $error("pump stage enable not taken from write");

   chk_skip_decode: assert property ( // R5
      @(posedge clock) disable iff (!reset_n)
      pump_cal_skip == (pump_cal_stage_enable == 2'h0))
      else $error("pump skip does not match stage enable");

   chk_pump_result: assert property ( // R6
      @(posedge clock) disable iff (!reset_n)
      (cal_update && !wr_pump) |=> pump_current == $past(cal_pump_result))
      else $error("pump result not stored");

   chk_pump_write: assert property ( // R6 R8
      @(posedge clock) disable iff (!reset_n)
      wr_pump |=> pump_current == $past(reg_wdata[3:0]))
      else $error("pump current not taken from write");

   chk_config_write: assert property ( // R7
      @(posedge clock) disable iff (!reset_n)
      wr_pump |=> pump_cal_config == $past(reg_wdata[7:6]))
      else $error("calibration config not taken from write");

   chk_config_hold: assert property ( // R7
      @(posedge clock) disable iff (!reset_n)
      !wr_pump |=> $stable(pump_cal_config))
      else $error("calibration config changed without a write");

   chk_hop_restore: assert property ( // R8 R10
      @(posedge clock) disable iff (!reset_n)
      (wr_osc && !cal_update) ##1 (!wr_osc && !cal_update)[*3]
      |-> oscillator_current == $past(reg_wdata[5:0], 3))
      else $error("restored oscillator value not held");

   chk_osc_write: assert property ( // R8 R10
      @(posedge clock) disable iff (!reset_n)
      wr_osc |=> oscillator_current == $past(reg_wdata[5:0]))
      else $error("oscillator current not taken from write");

   chk_osc_result: assert property ( // R10
      @(posedge clock) disable iff (!reset_n)
      (cal_update && !wr_osc)
      |=> oscillator_current == $past(cal_osc_result))
      else $error("oscillator result not stored");

   chk_core_select: assert property ( // R9
      @(posedge clock) disable iff (!reset_n)
      wr_osc |=> oscillator_core_high_select == $past(reg_wdata[5]))
      else $error("core select does not follow bit five");

   chk_unused_zero: assert property ( // R11
      @(posedge clock) disable iff (!reset_n)
      (reg_rd && reg_addr == TFSCR_OFS_FRONT_END)
      |=> reg_rdata[7:6] == 2'h0 && reg_rdata[3] == 1'b0)
      else $error("unused front end bits read nonzero");

   chk_front_read: assert property ( // R1 R4
      @(posedge clock) disable iff (!reset_n)
      (reg_rd && reg_addr == TFSCR_OFS_FRONT_END)
      |=> reg_rdata == {2'h0, $past(lob_r), 1'b0, $past(pli_r)})
      else $error("front end register read back wrong");

   chk_pump_read: assert property ( // R6 R7
      @(posedge clock) disable iff (!reset_n)
      (reg_rd && reg_addr == TFSCR_OFS_CAL_PUMP)
      |=> reg_rdata == {$past(pcfg_r), $past(pen_r), $past(pcur_r)})
      else $error("pump register read back wrong");

   chk_osc_unused: assert property ( // R10 R11
      @(posedge clock) disable iff (!reset_n)
      (reg_rd && reg_addr == TFSCR_OFS_CAL_OSC)
      |=> reg_rdata == {2'h0, $past(ocur_r)})
      else $error("oscillator register read back wrong");

   chk_unmapped_read: assert property ( // R11
      @(posedge clock) disable iff (!reset_n)
      (reg_rd && reg_addr != TFSCR_OFS_FRONT_END
       && reg_addr != TFSCR_OFS_CAL_PUMP && reg_addr != TFSCR_OFS_CAL_OSC)
      |=> reg_rdata == 8'h00)
      else $error("unmapped offset read nonzero");

   chk_hold_quiet: assert property ( // R8
      @(posedge clock) disable iff (!reset_n)
      (!reg_wr && !cal_update) |=> $stable(pcur_r) && $stable(ocur_r))
      else $error("calibration value changed with no cause");

   // ****************************************************************
   // Checks on the output level ramp.
   // ****************************************************************
   chk_ramp_down: assert property ( // R3
      @(posedge clock) disable iff (!reset_n)
      (step && !tx_active && table_index != 3'h0)
      |=> table_index == $past(table_index) - 3'h1)
      else $error("ramp down did not drop one entry");

   chk_ask_one: assert property ( // R2
      @(posedge clock) disable iff (!reset_n)
      (step && tx_active && ask_mode && tx_symbol
       && table_index < power_level_index)
      |=> table_index == $past(table_index) + 3'h1)
      else $error("ASK one symbol did not walk toward index");

   chk_idle_floor: assert property ( // R3
      @(posedge clock) disable iff (!reset_n)
      (!tx_active && table_index == 3'h0) |=> table_index == 3'h0)
      else $error("table index left entry zero while idle");
endmodule : tfscr_regs

// ===== tfscr_pkg.sv
// Constants for the transmit front end and synthesizer calibration registers.
package tfscr_pkg;
   // ****************************************************************
   // Register offsets.
   // ****************************************************************
   localparam logic [5:0] TFSCR_OFS_FRONT_END = 6'h22;
   localparam logic [5:0] TFSCR_OFS_CAL_PUMP  = 6'h23;
   localparam logic [5:0] TFSCR_OFS_CAL_OSC   = 6'h24;
   // ****************************************************************
   // Field positions and widths.
   // ****************************************************************
   localparam int TFSCR_PLI_LSB   = 0;
   localparam int TFSCR_PLI_W     = 3;
   localparam int TFSCR_LOB_LSB   = 4;
   localparam int TFSCR_LOB_W     = 2;
   localparam int TFSCR_PCUR_LSB  = 0;
   localparam int TFSCR_PCUR_W    = 4;
   localparam int TFSCR_PEN_LSB   = 4;
   localparam int TFSCR_PEN_W     = 2;
   localparam int TFSCR_PCFG_LSB  = 6;
   localparam int TFSCR_PCFG_W    = 2;
   localparam int TFSCR_OCUR_LSB  = 0;
   localparam int TFSCR_OCUR_W    = 6;
   localparam int TFSCR_CORE_BIT  = 5;
   localparam int TFSCR_TABLE_LEN = 8;
   // ****************************************************************
   // Reset values and writable masks.
   // ****************************************************************
   localparam logic [1:0] TFSCR_RST_LOB  = 2'h1;
   localparam logic [2:0] TFSCR_RST_PLI  = 3'h0;
   localparam logic [1:0] TFSCR_RST_PCFG = 2'h2;
   localparam logic [1:0] TFSCR_RST_PEN  = 2'h2;
   localparam logic [3:0] TFSCR_RST_PCUR = 4'h9;
   localparam logic [5:0] TFSCR_RST_OCUR = 6'h0A;
   localparam logic [7:0] TFSCR_MASK_FRONT_END = 8'h37;
   localparam logic [7:0] TFSCR_MASK_CAL_OSC   = 8'h3F;
   // ****************************************************************
   // Timing of the output level ramp.
   // ****************************************************************
   localparam int TFSCR_CLK_PERIOD_NS = 20;
   localparam int TFSCR_STEP_TIME_NS  = 1000;
   localparam int TFSCR_STEP_CYCLES   =
      (TFSCR_STEP_TIME_NS / TFSCR_CLK_PERIOD_NS < 1) ? 1 :
      TFSCR_STEP_TIME_NS / TFSCR_CLK_PERIOD_NS;
   localparam int TFSCR_STEP_CNT_W    = 6;
   typedef enum logic [1:0] {
      TFSCR_IDLE,
      TFSCR_RAMP,
      TFSCR_HOLD
   } tfscr_seq_type;
endpackage : tfscr_pkg

// ===== tfscr_step_div.sv
// Divider giving the one-cycle enable pulse that paces the level ramp.
`timescale 1ns/10ps
module tfscr_step_div
   import tfscr_pkg::*;
(
   input  wire logic clock,
   input  wire logic reset_n,
   input  wire logic run,
   output logic      step
);
   logic [TFSCR_STEP_CNT_W-1:0] cnt_r;
   logic [TFSCR_STEP_CNT_W-1:0] cnt_nxt;
   logic                        step_r;
   logic                        step_nxt;
   localparam logic [TFSCR_STEP_CNT_W-1:0] LAST =
      TFSCR_STEP_CNT_W'(TFSCR_STEP_CYCLES - 1);

   // Counting restarts when idle so the first step is a full period late.
   always_comb begin
      cnt_nxt  = cnt_r;
      step_nxt = 1'b0;
      if (!run) begin
         cnt_nxt = '0;
      end else if (cnt_r == LAST) begin
         cnt_nxt  = '0;
         step_nxt = 1'b1;
      end else begin
         cnt_nxt = cnt_r + 1'b1;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r  <= '0;
         step_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         step_r <= step_nxt;
      end
   end

   assign step = step_r;

   chk_step_period: assert property (@(posedge clock) disable iff (!reset_n)
      step |-> !$past(step))
      else $error("step pulse lasted more than one cycle");
endmodule : tfscr_step_div

// ===== tfscr_level_seq.sv
// Walks the output level table index toward its target one step at a time.
`timescale 1ns/10ps
module tfscr_level_seq
   import tfscr_pkg::*;
(
   input  wire logic             clock,
   input  wire logic             reset_n,
   input  wire logic             step,
   input  wire logic             tx_active,
   input  wire logic             ask_mode,
   input  wire logic             tx_symbol,
   input  wire logic [2:0]       power_level_index,
   output logic [2:0]            table_index,
   output logic                  ramp_busy
);
   tfscr_seq_type state_r;
   tfscr_seq_type state_nxt;
   logic [2:0]    idx_r;
   logic [2:0]    idx_nxt;
   logic [2:0]    target;

   // ASK zero symbols and the end of a frame both head for entry zero.
   always_comb begin
      target = 3'h0;
      if (tx_active && (!ask_mode || tx_symbol)) begin
         target = power_level_index;   // R1 R2
      end
   end

   always_comb begin
      idx_nxt   = idx_r;
      state_nxt = state_r;
      if (step) begin
         if (idx_r < target) begin
            idx_nxt = idx_r + 3'h1;   // R3
         end else if (idx_r > target) begin
            idx_nxt = idx_r - 3'h1;   // R3
         end
      end
      case (state_r)
         TFSCR_IDLE: begin
            if (tx_active) begin
               state_nxt = TFSCR_RAMP;
            end
         end
         TFSCR_RAMP: begin
            if (idx_nxt == target) begin
               state_nxt = tx_active ? TFSCR_HOLD : TFSCR_IDLE;
            end
         end
         TFSCR_HOLD: begin
            if (idx_r != target) begin
               state_nxt = TFSCR_RAMP;
            end
         end
         default: begin
            state_nxt = TFSCR_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         idx_r   <= 3'h0;
         state_r <= TFSCR_IDLE;
      end else begin
         idx_r   <= idx_nxt;
         state_r <= state_nxt;
      end
   end

   assign table_index = idx_r;
   assign ramp_busy   = (state_r == TFSCR_RAMP);

   chk_ask_zero: assert property ( // R2
      @(posedge clock) disable iff (!reset_n)
      (step && tx_active && ask_mode && !tx_symbol && idx_r != 3'h0)
      |=> idx_r == $past(idx_r) - 3'h1)
      else $error("ASK zero symbol did not walk toward entry zero");
   chk_ramp_one: assert property ( // R3
      @(posedge clock) disable iff (!reset_n)
      !step |=> idx_r == $past(idx_r))
      else $error("table index moved without a step pulse");
   chk_ramp_up: assert property ( // R3
      @(posedge clock) disable iff (!reset_n)
      (step && tx_active && !ask_mode && idx_r < power_level_index)
      |=> idx_r == $past(idx_r) + 3'h1)
      else $error("ramp up did not advance one entry");
endmodule : tfscr_level_seq

// ===== tfscr_host_model.sv
// Host model that reaches the registers through the parallel address, data and strobe port.
`timescale 1ns/10ps
module tfscr_host_model
   import tfscr_pkg::*;
(
   input  wire logic       clock,
   input  wire logic [7:0] reg_rdata,
   output logic [5:0]      reg_addr,
   output logic            reg_wr,
   output logic [7:0]      reg_wdata,
   output logic            reg_rd
);
   initial begin
      reg_addr  = 6'h00;
      reg_wr    = 1'b0;
      reg_wdata = 8'h00;
      reg_rd    = 1'b0;
   end
   // ****************************************************************
   // Byte transfers.
   // ****************************************************************
   // Released lines are inverted so a stale byte never passes for new.
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clock);
      reg_wr    <= 1'b0;
      reg_wdata <= ~d;
   endtask : wr
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clock);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      @(posedge clock);
      d = reg_rdata;
   endtask : rd
endmodule : tfscr_host_model

// ===== tb.sv
// Self-checking bench for the front end and calibration register bank.
`timescale 1ns/10ps
module tb
   import tfscr_pkg::*;
;
   logic       clock = 1'b0;
   logic       reset_n = 1'b0;
   logic [5:0] reg_addr;
   logic       reg_wr;
   logic [7:0] reg_wdata;
   logic       reg_rd;
   logic [7:0] reg_rdata;
   logic       cal_update = 1'b0;
   logic [3:0] cal_pump_result = 4'h0;
   logic [5:0] cal_osc_result = 6'h00;
   logic       tx_active = 1'b0;
   logic       ask_mode = 1'b0;
   logic       tx_symbol = 1'b0;
   logic [2:0] power_level_index;
   logic [1:0] lo_buffer_drive_setting;
   logic [1:0] pump_cal_config;
   logic [1:0] pump_cal_stage_enable;
   logic       pump_cal_skip;
   logic [3:0] pump_current;
   logic       oscillator_core_high_select;
   logic [5:0] oscillator_current;
   logic [2:0] table_index;
   logic       ramp_busy;
   logic [7:0] fe = 8'h10;
   logic [7:0] cp = 8'hA9;
   logic [7:0] co = 8'h0A;
   logic [7:0] sp;
   logic [7:0] so;
   int         err_total = 0;
   int         checked = 0;
   always #10 clock = ~clock;
   tfscr_host_model host_u (.clock(clock), .reg_rdata(reg_rdata),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd));
   tfscr_regs dut_u (.clock(clock), .reset_n(reset_n),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cal_update(cal_update),
      .cal_pump_result(cal_pump_result), .cal_osc_result(cal_osc_result),
      .tx_active(tx_active), .ask_mode(ask_mode), .tx_symbol(tx_symbol),
      .power_level_index(power_level_index),
      .lo_buffer_drive_setting(lo_buffer_drive_setting),
      .pump_cal_config(pump_cal_config),
      .pump_cal_stage_enable(pump_cal_stage_enable),
      .pump_cal_skip(pump_cal_skip), .pump_current(pump_current),
      .oscillator_core_high_select(oscillator_core_high_select),
      .oscillator_current(oscillator_current),
      .table_index(table_index), .ramp_busy(ramp_busy));
   // ****************************************************************
   // Checking helpers.
   // ****************************************************************
   task automatic give_verdict();
      $display("errors %0d checks %0d", err_total, checked);
      if (err_total == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : give_verdict
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
      checked++;
      if (got !== exp) begin
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
         err_total++;
      end
   endtask : cmp
   // Unused bits are dropped here, so expectations never carry them.
   task automatic host_write(input logic [5:0] a, input logic [7:0] d);
      host_u.wr(a, d);
      if (a == TFSCR_OFS_FRONT_END)
         fe = d & TFSCR_MASK_FRONT_END;
      else if (a == TFSCR_OFS_CAL_PUMP)
         cp = d;
      else if (a == TFSCR_OFS_CAL_OSC)
         co = d & TFSCR_MASK_CAL_OSC;
   endtask : host_write
   task automatic cal_pulse(input logic [3:0] p, input logic [5:0] o);
      @(posedge clock);
      cal_pump_result <= p;
      cal_osc_result  <= o;
      cal_update      <= 1'b1;
      @(posedge clock);
      cal_update      <= 1'b0;
      cal_pump_result <= ~p;
      cal_osc_result  <= ~o;
   endtask : cal_pulse
   task automatic chk_all();
      logic [7:0] d;
      @(posedge clock);
      cmp({5'h00, power_level_index}, {5'h00, fe[2:0]}, "index");
      cmp({6'h00, lo_buffer_drive_setting}, {6'h00, fe[5:4]}, "buf");
      cmp({6'h00, pump_cal_config}, {6'h00, cp[7:6]}, "config");
      cmp({6'h00, pump_cal_stage_enable}, {6'h00, cp[5:4]}, "en");
      cmp({7'h00, pump_cal_skip}, {7'h00, cp[5:4] == 2'h0}, "skip");
      cmp({4'h0, pump_current}, {4'h0, cp[3:0]}, "pump");
      cmp({7'h00, oscillator_core_high_select}, {7'h00, co[5]}, "core");
      cmp({2'h0, oscillator_current}, {2'h0, co[5:0]}, "osc");
      host_u.rd(6'h22, d);
      cmp(d, fe, "read front end");
      host_u.rd(6'h23, d);
      cmp(d, cp, "read pump");
      host_u.rd(6'h24, d);
      cmp(d, co, "read osc");
      host_u.rd(6'h25, d);
      cmp(d, 8'h00, "read unmapped");
   endtask : chk_all
   // Each move of the index must be one entry toward the target.
   task automatic walk(input logic [2:0] tgt);
      int         n;
      int         steps;
      int         lo;
      int         hi;
      logic [2:0] last;
      logic [2:0] want;
      n = 0;
      steps = 0;
      last = table_index;
      while ((table_index !== tgt || ramp_busy !== 1'b0) && n < 600) begin
         @(posedge clock);
         n++;
         if (table_index !== last) begin
            want = (tgt > last) ? last + 3'h1 : last - 3'h1;
            cmp({5'h00, table_index}, {5'h00, want}, "step");
            steps++;
            last = table_index;
         end
      end
      cmp({5'h00, table_index}, {5'h00, tgt}, "target");
      cmp({7'h00, ramp_busy}, 8'h00, "busy");
      // The pacer may be mid-period when a walk starts, so the first
      // step can come anywhere within one period.
      lo = TFSCR_STEP_CYCLES * (steps - 1);
      hi = TFSCR_STEP_CYCLES * steps + 10;
      cmp({7'h00, n >= lo && n <= hi}, 8'h01, "pace");
   endtask : walk
   // ****************************************************************
   // Main sequence.
   // ****************************************************************
   initial begin
      repeat (20000) @(posedge clock);
      err_total++;
      give_verdict();
   end
   initial begin
      void'($urandom(32'h5FECC85B));
      repeat (5) @(posedge clock);
      reset_n <= 1'b1;
      chk_all();
      cmp({5'h00, table_index}, 8'h00, "reset index");
      for (int k = 0; k < 6; k++) begin
         host_write(6'h22 + 6'(k % 3), (k < 3) ? 8'h00 : 8'hFF);
         chk_all();
      end
      for (int i = 0; i < 24; i++) begin
         host_write(($urandom % 4 == 3) ? 6'h30 : 6'h22 + 6'($urandom % 3),
                    8'($urandom));
         chk_all();
      end
      host_write(6'h23, {2'h2, 2'h2, cp[3:0]});
      sp = 8'($urandom);
      cal_pulse(sp[3:0], sp[7:2]);
      cp[3:0] = sp[3:0];
      co[5:0] = sp[7:2];
      chk_all();
      sp = cp;
      so = co;
      cal_pulse(~sp[3:0], ~so[5:0]);
      cp[3:0] = ~sp[3:0];
      co[5:0] = ~so[5:0];
      chk_all();
      host_write(6'h23, sp);
      fork
         host_write(6'h24, so);
         cal_pulse(4'h3, 6'h15);
      join
      cp[3:0] = 4'h3;
      chk_all();
      host_write(6'h22, 8'h13);
      @(posedge clock);
      tx_active <= 1'b1;
      walk(3'h3);
      tx_active <= 1'b0;
      walk(3'h0);
      host_write(6'h22, 8'h25);
      @(posedge clock);
      ask_mode  <= 1'b1;
      tx_active <= 1'b1;
      repeat (120) @(posedge clock);
      cmp({5'h00, table_index}, 8'h00, "ask zero");
      tx_symbol <= 1'b1;
      walk(3'h5);
      tx_symbol <= 1'b0;
      walk(3'h0);
      tx_active <= 1'b0;
      give_verdict();
   end
endmodule : tb
